// ===== hw/spat_top.sv
// Purpose: Serial port, async transmitter and sync master receiver
// Assumes: Classic Wishbone slave, 100 MHz clk_i, sync reset
// Notes: Pin levels leave through flip-flops, one cycle behind the logic
//
// Notes on behaviour
// - Idle mark, start space, 8/9 data, stop mark
// - Each transmitted bit lasts one baud period
// - Data bits least significant first
// - Independent directions, shared format and baud
// - No hardware parity; ninth bit carries it
// - Async transmit needs enable, async, port on
// - Port enable drives the clock pin out
// - Transmit enable raises buffer-empty flag
// - Write starts sending; empty shifter loads at once
// - Queued char loads after stop, within cycle
// - Polarity bit inverts async idle and data
// - Empty flag set unless shifter busy and queued
// - Empty flag valid second cycle after write
// - Interrupt enable only gates the request
// - Sync master receive releases the data pin
// - Single or continuous enable starts reception
// - Single receive: one character, then cleared
// - Continuous clear stops clock, drops partial
// - Both set: single clears after first
// - Sample data on trailing clock edge
// - Two-deep buffer, ready flag while unread
// - Third char when full: overrun, blocks reception
// - Ninth bit of top entry shown as status
//
// The Wishbone interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "spat_defs.svh"
module spat_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic transmit_clock_pin_o,
  output logic transmit_clock_pin_oe_o,
  output logic receive_data_pin_o,
  output logic receive_data_pin_oe_o,
  input wire logic receive_data_pin_i,
  output logic tx_request_o
);

  // ==========================================================
  // State of the whole block
  typedef struct packed {
    logic ack; // Bus answer
    logic [31:0] dat; // Read data held with ack
    logic serial_port_enable; // Port on
    logic transmit_enable_bit; // Transmitter on
    logic sync; // Clocked mode select
    logic polarity_select_bit; // Async output inversion
    logic nine; // Nine-bit characters, both directions
    logic single_receive_enable; // One character
    logic continuous_receive_enable; // Run until cleared
    logic transmit_irq_enable; // Request gate
    logic [15:0] baud; // Shared divisor
    logic [8:0] thr; // Transmit holding register
    logic thr_full; // Character queued
    spat_pkg::spat_tx_st_t tx_st; // Transmit sequencer
    logic [8:0] transmit_shift_register; // Transmit shift register
    logic [3:0] tbit; // Data bits sent
    logic transmit_buffer_empty_flag; // Transmit buffer empty flag
    logic txreq; // Gated request
    logic rx_m; // Pin synchroniser, first stage
    logic rx_s; // Pin synchroniser, second stage
    logic ck; // Generated receive clock
    logic [3:0] rbit; // Data bits sampled
    logic [8:0] receive_shift_register; // Receive shift register
    logic [1:0][8:0] fifo; // Receive buffer, entry 0 on top
    logic [1:0] cnt; // Unread characters
    logic overrun_error_flag; // Overrun error flag
    logic ovr_cont; // Overrun seen in continuous mode
    logic pin; // Clock/transmit pin level
    logic pin_oe; // Clock/transmit pin driven
  } spat_st_t;

  spat_st_t s_q;
  spat_st_t s_d;

  spat_if tx_b (); // Transmit baud divider
  spat_if rx_b (); // Receive clock divider

  // ==========================================================
  // Baud dividers, one per direction but one divisor
  spat_baud u_tx_baud (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .b(tx_b)
  );

  spat_baud u_rx_baud (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .b(rx_b)
  );

  logic tx_on; // Async transmitter active
  logic rx_on; // Sync master receiver active

  assign tx_on = s_q.serial_port_enable & s_q.transmit_enable_bit & ~s_q.sync;
  assign rx_on = s_q.serial_port_enable & s_q.sync & ~s_q.overrun_error_flag
               & (s_q.single_receive_enable | s_q.continuous_receive_enable);

  assign tx_b.div = s_q.baud;
  assign rx_b.div = s_q.baud;
  // Idle sequencer holds the divider so the start bit gets a full period
  assign tx_b.clr = (s_q.tx_st == spat_pkg::SPAT_TX_IDLE);
  // Dropping enable stops the clock at once
  assign rx_b.clr = ~rx_on;

  // ==========================================================
  // Outputs straight from flip-flops
  assign dat_o = s_q.dat;
  assign ack_o = s_q.ack;
  assign transmit_clock_pin_o = s_q.pin;
  assign transmit_clock_pin_oe_o = s_q.pin_oe;
  assign receive_data_pin_o = 1'b0;
  assign receive_data_pin_oe_o = 1'b0;
  assign tx_request_o = s_q.txreq;

  // ==========================================================
  // Next state
  always_comb begin
    logic take; // Effect cycle of a bus access
    logic wr; // Write in effect
    logic pop; // Receive data read
    logic line; // Async line level before inversion
    logic done; // Character complete
    logic [3:0] last; // Index of final data bit
    logic [8:0] shifted; // Receive shifter after sample
    logic [8:0] chr; // Completed character
    logic [31:0] rdv; // Read value
    take = 1'b0;
    wr = 1'b0;
    pop = 1'b0;
    line = 1'b1;
    done = 1'b0;
    last = `SPAT_LAST8;
    shifted = 9'h000;
    chr = 9'h000;
    rdv = 32'h0000_0000;
    s_d = s_q;

    // Common character length for both directions
    if (s_q.nine) begin
      last = `SPAT_LAST9;
    end

    // Bus: answer one cycle after the request, act while ack stands
    take = cyc_i & stb_i & s_q.ack;
    wr = take & we_i;
    s_d.ack = cyc_i & stb_i & ~s_q.ack;
    pop = take & ~we_i & (adr_i == `SPAT_OFF_RXD) & (s_q.cnt != 2'h0);

    // Read mux, unmapped reads zero
    unique case (adr_i)
      `SPAT_OFF_CTRL: begin
        rdv[`SPAT_C_SERIAL_PORT_ENABLE] = s_q.serial_port_enable;
        rdv[`SPAT_C_TRANSMIT_ENABLE_BIT] = s_q.transmit_enable_bit;
        rdv[`SPAT_C_SYNC] = s_q.sync;
        rdv[`SPAT_C_POL] = s_q.polarity_select_bit;
        rdv[`SPAT_C_NINE] = s_q.nine;
        rdv[`SPAT_C_SINGLE_RECEIVE_ENABLE] = s_q.single_receive_enable;
        rdv[`SPAT_C_CONTINUOUS_RECEIVE_ENABLE] = s_q.continuous_receive_enable;
        rdv[`SPAT_C_TRANSMIT_IRQ_ENABLE] = s_q.transmit_irq_enable;
      end
      `SPAT_OFF_STAT: begin
        rdv[`SPAT_S_TRANSMIT_BUFFER_EMPTY_FLAG] = s_q.transmit_buffer_empty_flag;
        rdv[`SPAT_S_RXRDY] = (s_q.cnt != 2'h0);
        rdv[`SPAT_S_OVERRUN_ERROR_FLAG] = s_q.overrun_error_flag;
        rdv[`SPAT_S_RECEIVED_NINTH_BIT] = s_q.fifo[0][8];
        rdv[`SPAT_S_TBUSY] = (s_q.tx_st != spat_pkg::SPAT_TX_IDLE);
      end
      `SPAT_OFF_TXD: rdv[8:0] = s_q.thr;
      `SPAT_OFF_RXD: rdv[7:0] = s_q.fifo[0][7:0];
      `SPAT_OFF_BAUD: rdv[15:0] = s_q.baud;
      default: rdv = 32'h0000_0000;
    endcase
    if (cyc_i && stb_i && !s_q.ack) begin
      s_d.dat = rdv;
    end

    // ========================================================
    // Async transmitter
    if (!tx_on) begin
      s_d.tx_st = spat_pkg::SPAT_TX_IDLE;
      s_d.thr_full = 1'b0; // Disabling drops a queued character
    end else begin
      unique case (s_q.tx_st)
        spat_pkg::SPAT_TX_IDLE: begin
          if (s_q.thr_full) begin
            s_d.transmit_shift_register = s_q.thr;
            s_d.thr_full = 1'b0;
            s_d.tbit = 4'h0;
            s_d.tx_st = spat_pkg::SPAT_TX_START;
          end
        end
        spat_pkg::SPAT_TX_START: begin
          if (tx_b.tick) begin
            s_d.tx_st = spat_pkg::SPAT_TX_DATA;
          end
        end
        spat_pkg::SPAT_TX_DATA: begin
          if (tx_b.tick) begin
            s_d.transmit_shift_register = {1'b0, s_q.transmit_shift_register[8:1]};
            s_d.tbit = s_q.tbit + 4'h1;
            if (s_q.tbit == last) begin
              s_d.tx_st = spat_pkg::SPAT_TX_STOP;
            end
          end
        end
        spat_pkg::SPAT_TX_STOP: begin
          if (tx_b.tick) begin
            if (s_q.thr_full) begin
              // Back to back: load in the stop's final cycle, no gap
              s_d.transmit_shift_register = s_q.thr;
              s_d.thr_full = 1'b0;
              s_d.tbit = 4'h0;
              s_d.tx_st = spat_pkg::SPAT_TX_START;
            end else begin
              s_d.tx_st = spat_pkg::SPAT_TX_IDLE;
            end
          end
        end
      endcase
    end

    // Line level for the current bit
    unique case (s_q.tx_st)
      spat_pkg::SPAT_TX_START: line = 1'b0;
      spat_pkg::SPAT_TX_DATA: line = s_q.transmit_shift_register[0];
      spat_pkg::SPAT_TX_IDLE, spat_pkg::SPAT_TX_STOP: line = 1'b1;
    endcase

    // Holding register write; a full register is overwritten
    if (wr && (adr_i == `SPAT_OFF_TXD) && sel_i[0]) begin
      s_d.thr[7:0] = dat_i[7:0];
      if (sel_i[1]) begin
        s_d.thr[8] = dat_i[8];
      end
      s_d.thr_full = tx_on;
    end

    // Flag follows the registered holding state, so it settles late
    s_d.transmit_buffer_empty_flag = s_q.transmit_enable_bit & ~s_q.thr_full;
    s_d.txreq = s_q.transmit_buffer_empty_flag & s_q.transmit_irq_enable;

    // ========================================================
    // Sync master receiver
    s_d.rx_m = receive_data_pin_i;
    s_d.rx_s = s_q.rx_m;
    shifted = {s_q.rx_s, s_q.receive_shift_register[8:1]};
    if (!rx_on) begin
      s_d.ck = 1'b0;
      s_d.rbit = 4'h0;
    end else if (rx_b.tick) begin
      if (!s_q.ck) begin
        s_d.ck = 1'b1; // Leading edge
      end else begin
        s_d.ck = 1'b0;
        s_d.receive_shift_register = shifted;
        s_d.rbit = s_q.rbit + 4'h1;
        if (s_q.rbit == last) begin
          s_d.rbit = 4'h0;
          done = 1'b1;
        end
      end
    end

    // Align the character to bit 0
    chr = s_q.nine ? shifted : {1'b0, shifted[8:1]};

    // Pop the top entry first, then push
    if (pop) begin
      s_d.fifo[0] = s_q.fifo[1];
      s_d.cnt = s_q.cnt - 2'h1;
    end

    // Overrun clears by read in single mode, by disable otherwise
    if (s_q.overrun_error_flag && (!s_q.serial_port_enable
        || (s_q.ovr_cont ? !s_q.continuous_receive_enable : pop))) begin
      s_d.overrun_error_flag = 1'b0;
    end

    if (done) begin
      s_d.single_receive_enable = 1'b0;
      if (s_d.cnt == `SPAT_FIFO_FULL) begin
        s_d.overrun_error_flag = 1'b1;
        s_d.ovr_cont = s_q.continuous_receive_enable;
      end else begin
        s_d.fifo[s_d.cnt[0]] = chr;
        s_d.cnt = s_d.cnt + 2'h1;
      end
    end

    // Port off empties the buffer
    if (!s_q.serial_port_enable) begin
      s_d.cnt = 2'h0;
    end

    // ========================================================
    // Control and baud writes, after hardware so a set wins
    if (wr && (adr_i == `SPAT_OFF_CTRL) && sel_i[0]) begin
      s_d.serial_port_enable = dat_i[`SPAT_C_SERIAL_PORT_ENABLE];
      s_d.transmit_enable_bit = dat_i[`SPAT_C_TRANSMIT_ENABLE_BIT];
      s_d.sync = dat_i[`SPAT_C_SYNC];
      s_d.polarity_select_bit = dat_i[`SPAT_C_POL];
      s_d.nine = dat_i[`SPAT_C_NINE];
      s_d.single_receive_enable = dat_i[`SPAT_C_SINGLE_RECEIVE_ENABLE];
      s_d.continuous_receive_enable = dat_i[`SPAT_C_CONTINUOUS_RECEIVE_ENABLE];
      s_d.transmit_irq_enable = dat_i[`SPAT_C_TRANSMIT_IRQ_ENABLE];
    end
    if (wr && (adr_i == `SPAT_OFF_BAUD)) begin
      if (sel_i[0]) begin
        s_d.baud[7:0] = dat_i[7:0];
      end
      if (sel_i[1]) begin
        s_d.baud[15:8] = dat_i[15:8];
      end
    end

    // ========================================================
    // Pin: clock in sync mode, data line otherwise
    if (s_q.sync) begin
      s_d.pin = s_q.ck;
    end else begin
      s_d.pin = line ^ s_q.polarity_select_bit;
    end
    s_d.pin_oe = s_q.serial_port_enable;
  end

  // ==========================================================
  // Single register for all state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.baud <= `SPAT_BAUD_RST;
      s_q.pin <= 1'b1; // Mark level
    end else begin
      s_q <= s_d;
    end
  end

endmodule : spat_top

// ===== include/spat_defs.svh
// Purpose: Offsets, field positions, reset values for the serial port
// Assumes: 32-bit classic Wishbone, byte addresses, one word per register
// Notes: Definitions only
`ifndef SPAT_DEFS_SVH
`define SPAT_DEFS_SVH

// ==========================================================
// Register byte offsets
`define SPAT_OFF_CTRL 8'h00
`define SPAT_OFF_STAT 8'h04
`define SPAT_OFF_TXD 8'h08
`define SPAT_OFF_RXD 8'h0C
`define SPAT_OFF_BAUD 8'h10

// ==========================================================
// Control register fields
`define SPAT_C_SERIAL_PORT_ENABLE 0
`define SPAT_C_TRANSMIT_ENABLE_BIT 1
`define SPAT_C_SYNC 2
`define SPAT_C_POL 3
`define SPAT_C_NINE 4
`define SPAT_C_SINGLE_RECEIVE_ENABLE 5
`define SPAT_C_CONTINUOUS_RECEIVE_ENABLE 6
`define SPAT_C_TRANSMIT_IRQ_ENABLE 7

// ==========================================================
// Status register fields
`define SPAT_S_TRANSMIT_BUFFER_EMPTY_FLAG 0
`define SPAT_S_RXRDY 1
`define SPAT_S_OVERRUN_ERROR_FLAG 2
`define SPAT_S_RECEIVED_NINTH_BIT 3
`define SPAT_S_TBUSY 4

// ==========================================================
// Reset values and character lengths
`define SPAT_BAUD_RST 16'h0363
`define SPAT_LAST8 4'h7
`define SPAT_LAST9 4'h8
`define SPAT_FIFO_FULL 2'h2

`endif

// ===== include/spat_pkg.sv
// Purpose: Types shared by the serial port modules
// Assumes: Constants live in spat_defs.svh
// Notes: Gray-coded transmit states
package spat_pkg;

  // ==========================================================
  // Transmit sequencer states, Gray along idle-start-data-stop
  typedef enum logic [1:0] {
    SPAT_TX_IDLE = 2'h0,
    SPAT_TX_START = 2'h1,
    SPAT_TX_DATA = 2'h3,
    SPAT_TX_STOP = 2'h2
  } spat_tx_st_t;

endpackage : spat_pkg

// ===== include/spat_if.sv
// Purpose: Link between a baud divider and its user
// Assumes: One clock domain
// Notes: tick is a one-cycle strobe
`timescale 1ns/1ps
interface spat_if;
  logic clr; // Restart the divider
  logic [15:0] div; // Period minus one
  logic tick; // End of one period

  modport gen (input clr, input div, output tick);
  modport user (output clr, output div, input tick);
endinterface : spat_if

// ===== hw/spat_baud.sv
// Purpose: Baud period divider
// Assumes: div is steady while running
// Notes: Period is div+1 clocks; tick is combinational from the count
`timescale 1ns/1ps
module spat_baud (
  input wire logic clk_i,
  input wire logic rst_i,
  spat_if.gen b
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [15:0] cnt; // Cycles into the period
  } spat_baud_st_t;

  spat_baud_st_t s_q;
  spat_baud_st_t s_d;

  // Tick on last cycle of the period; held off while cleared
  assign b.tick = (s_q.cnt == b.div) & ~b.clr;

  // ==========================================================
  // Next count
  always_comb begin
    s_d = s_q;
    if (b.clr || b.tick) begin
      s_d.cnt = 16'h0000; // Restart, keeps each period exact
    end else begin
      s_d.cnt = s_q.cnt + 16'h0001;
    end
  end

  // Register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : spat_baud

// ===== bench/spat_chk.sv
// Purpose: Port-level checks for the serial port
// Assumes: Configuration only changes while the line is quiet
// Notes: CTRL and BAUD are shadowed from bus writes
`timescale 1ns/1ps
`include "spat_defs.svh"
module spat_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic ack_o,
  input wire logic transmit_clock_pin_o,
  input wire logic transmit_clock_pin_oe_o,
  input wire logic receive_data_pin_o,
  input wire logic receive_data_pin_oe_o,
  input wire logic tx_request_o
);
  // ==========================================================
  // Shadow state
  logic [7:0] ctrl_q; // CTRL as last written
  logic [15:0] baud_q; // BAUD as last written
  logic [7:0] age_q; // Cycles since a CTRL write
  logic [15:0] run_q; // Length of the pin level just ended
  logic pin_q; // Pin one cycle ago
  logic wr; // Write taking effect
  assign wr = cyc_i & stb_i & we_i & ack_o;
  // Same edge as the design's own registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= 8'h00;
      baud_q <= `SPAT_BAUD_RST;
      age_q <= 8'h00;
      run_q <= 16'h0000;
      pin_q <= 1'b1;
    end else begin
      if (wr && adr_i == `SPAT_OFF_CTRL) begin
        ctrl_q <= dat_i[7:0];
      end
      if (wr && adr_i == `SPAT_OFF_BAUD) begin
        baud_q <= dat_i[15:0];
      end
      // Saturates, so long quiet spells stay visible
      age_q <= (wr && adr_i == `SPAT_OFF_CTRL) ? 8'h00 : age_q + {7'h00, age_q != 8'hFF};
      run_q <= (transmit_clock_pin_o != pin_q) ? 16'h0001 : run_q + 16'h0001;
      pin_q <= transmit_clock_pin_o;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================================
  // Assertions
  a_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("no answer");
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("answer too long");
  a_pin_drive: assert property (transmit_clock_pin_oe_o == $past(ctrl_q[0]))
    else $error("clock pin drive wrong");
  a_data_released: assert property (!receive_data_pin_oe_o && !receive_data_pin_o)
    else $error("data pin driven");
  a_req_gated: assert property (tx_request_o |-> $past(ctrl_q[7]))
    else $error("request while disabled");
  // Only space runs are whole bits; idle mark may be any length
  a_bit_whole: assert property (ctrl_q[2:0] == 3'h3 && age_q > 8'h08 && transmit_clock_pin_o != pin_q
    && transmit_clock_pin_o == !ctrl_q[3] |-> run_q % (baud_q + 16'h0001) == 16'h0000)
    else $error("bit length wrong");
  a_half_period: assert property (ctrl_q[2:0] == 3'h5 && age_q > 8'h08 && !transmit_clock_pin_o && pin_q
    |-> run_q == baud_q + 16'h0001)
    else $error("clock high phase wrong");
  a_tx_quiet: assert property (ctrl_q[2:0] == 3'h1 && age_q > 8'h64 |-> transmit_clock_pin_o == !ctrl_q[3])
    else $error("line not idle");
  a_clock_stop: assert property (ctrl_q[2] && ctrl_q[0] && ctrl_q[6:5] == 2'h0 && age_q > 8'h04
    |-> !(transmit_clock_pin_o && !pin_q))
    else $error("clock runs");
endmodule : spat_chk

// ===== bench/spat_remote.sv
// Purpose: Remote synchronous slave answering the master clock
// Assumes: Clock idles low between characters
// Notes: Line shows junk once its hold time has passed; eight or nine bits a character
`timescale 1ns/1ps
module spat_remote (
  input wire logic ck_i, // Master clock
  input wire logic restart_i, // Back to bit 0
  input wire logic nine_i, // Nine-bit characters
  input wire logic [8:0] word_i, // Character to send
  output logic dt_o // Data line
);
  int idx; // Next bit
  initial begin
    idx = 0;
    dt_o = 1'b1;
  end
  always @(posedge restart_i) idx = 0;
  // New bit on the leading edge, least significant first
  always @(posedge ck_i) begin
    dt_o = word_i[idx];
    idx = (idx + 1) % (nine_i ? 9 : 8);
  end
  // Hold over: invert so a stale bit never passes for data
  // Odd delay keeps the change off the master's clock edges
  always @(negedge ck_i) begin
    #33 dt_o = ~dt_o;
  end
endmodule : spat_remote

// ===== bench/spat_tb.sv
// Purpose: Self-checking bench for the serial port
// Assumes: BAUD is set to 7, one bit is 8 clocks
// Notes: Async frames are decoded by a mid-bit sampler
`timescale 1ns/1ps
`include "spat_defs.svh"
module testbench;
  // ==========================================================
  // Signals
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, transmit_clock_pin_o, transmit_clock_pin_oe_o;
  logic receive_data_pin_o, receive_data_pin_oe_o, receive_data_pin_i, tx_request_o, dt, pin_q, restart;
  logic pol_q, nine_q, dec_on; // Decoder settings
  logic [7:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, rd; // rd is the last read
  logic [8:0] word; // Remote character
  logic [10:0] fr; // Frame being sampled
  logic [10:0] got[$]; // Decoded frames
  int n_mismatch, comparisons, cycles, rises, gap, idle_n, r0;
  localparam int BIT = 8;
  localparam logic [7:0] A_CT = `SPAT_OFF_CTRL;
  localparam logic [7:0] A_ST = `SPAT_OFF_STAT;
  localparam logic [7:0] A_TX = `SPAT_OFF_TXD;
  localparam logic [7:0] A_RX = `SPAT_OFF_RXD;
  spat_top i_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
    .transmit_clock_pin_o, .transmit_clock_pin_oe_o, .receive_data_pin_o, .receive_data_pin_oe_o, .receive_data_pin_i, .tx_request_o);
  spat_remote i_remote (.ck_i(transmit_clock_pin_o), .restart_i(restart), .nine_i(nine_q), .word_i(word), .dt_o(dt));
  // Wire level from both drivers
  assign receive_data_pin_i = receive_data_pin_oe_o ? receive_data_pin_o : dt;
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Cycle count, clock rises, hang guard
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    pin_q <= transmit_clock_pin_o;
    if (transmit_clock_pin_o && !pin_q) rises <= rises + 1;
    if (cycles == 20000) begin
      n_mismatch = n_mismatch + 1;
      finish_test();
    end
  end
  // Async decoder, one sample in the middle of each bit
  always begin
    @(posedge clk_i);
    idle_n++;
    if (dec_on && transmit_clock_pin_o === pol_q) begin
      gap = idle_n;
      fr = 11'h000;
      for (int i = 0; i < (nine_q ? 11 : 10); i++) begin
        repeat (i == 0 ? BIT / 2 : BIT) @(posedge clk_i);
        fr[i] = transmit_clock_pin_o ^ pol_q;
      end
      got.push_back(fr);
      idle_n = 0;
    end
  end
  // ==========================================================
  // Shared tasks
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    sel_i <= 4'h3;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask : check
  // Wait for a decoded frame; start 0, data, stop 1
  task automatic frame(input logic [8:0] d);
    logic [10:0] e;
    e = nine_q ? {1'b1, d, 1'b0} : {2'b01, d[7:0], 1'b0};
    while (got.size() == 0) @(posedge clk_i);
    check(32'(got.pop_front()), 32'(e));
  endtask : frame
  task automatic poll(input int b);
    do wb(1'b0, A_ST, 32'h0); while (rd[b] !== 1'b1);
  endtask : poll
  task automatic remote(input logic [8:0] w);
    word <= w;
    restart <= 1'b1;
    @(posedge clk_i);
    restart <= 1'b0;
  endtask : remote
  task automatic finish_test();
    $display("TB: %0d bad of %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test
  // ==========================================================
  // Scenarios
  task automatic t_regs();
    wb(1'b0, A_CT, 32'h0);
    check(rd, 32'h0);
    wb(1'b0, `SPAT_OFF_BAUD, 32'h0);
    check(rd, 32'(`SPAT_BAUD_RST));
    wb(1'b1, 8'h14, 32'hFF);
    wb(1'b0, 8'h14, 32'h0);
    check(rd, 32'h0);
    wb(1'b0, A_ST, 32'h0);
    check(32'(rd[0]), 32'h0);
    wb(1'b1, `SPAT_OFF_BAUD, 32'h7);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_tx();
    wb(1'b1, A_CT, 32'h83);
    wb(1'b0, A_ST, 32'h0);
    check(32'(rd[0]), 32'h1);
    check(32'(transmit_clock_pin_oe_o), 32'h1);
    check(32'(tx_request_o), 32'h1);
    wb(1'b1, A_TX, 32'hA5);
    wb(1'b1, A_TX, 32'h3C);
    wb(1'b1, A_CT, 32'h03);
    wb(1'b0, A_ST, 32'h0);
    check(32'(rd[0]), 32'h0);
    frame(9'h0A5);
    frame(9'h03C);
    check(32'(gap <= BIT / 2 + 1), 32'h1);
    wb(1'b0, A_ST, 32'h0);
    check(32'(rd[0]), 32'h1);
    $display("t_tx done");
  endtask : t_tx
  task automatic t_pol();
    dec_on = 1'b0;
    wb(1'b1, A_CT, 32'h09);
    wb(1'b1, A_TX, 32'h00);
    repeat (30) @(posedge clk_i);
    check(32'(transmit_clock_pin_o), 32'h0);
    repeat (90) @(posedge clk_i);
    pol_q = 1'b1;
    nine_q = 1'b1;
    dec_on = 1'b1;
    wb(1'b1, A_CT, 32'h1B);
    wb(1'b1, A_TX, 32'h15A);
    frame(9'h15A);
    dec_on = 1'b0;
    nine_q = 1'b0;
    $display("t_pol done");
  endtask : t_pol
  task automatic t_single();
    wb(1'b1, A_CT, 32'h05);
    remote(9'h0C3);
    r0 = rises;
    wb(1'b1, A_CT, 32'h25);
    poll(1);
    repeat (4 * BIT) @(posedge clk_i);
    check(rises - r0, 8);
    wb(1'b0, A_CT, 32'h0);
    check(32'(rd[5]), 32'h0);
    wb(1'b0, A_RX, 32'h0);
    check(32'(rd[7:0]), 32'hC3);
    wb(1'b0, A_ST, 32'h0);
    check(32'(rd[1]), 32'h0);
    $display("t_single done");
  endtask : t_single
  // Nine-bit single receive: ninth bit shows in status before the pop
  task automatic t_nine();
    nine_q = 1'b1;
    remote(9'h15A);
    r0 = rises;
    wb(1'b1, A_CT, 32'h35);
    poll(1);
    repeat (4 * BIT) @(posedge clk_i);
    check(rises - r0, 9);
    wb(1'b0, A_ST, 32'h0);
    check(32'(rd[3]), 32'h1);
    wb(1'b0, A_RX, 32'h0);
    check(32'(rd[7:0]), 32'h5A);
    wb(1'b1, A_CT, 32'h05);
    nine_q = 1'b0;
    $display("t_nine done");
  endtask : t_nine
  task automatic t_cont();
    remote(9'h096);
    wb(1'b1, A_CT, 32'h65);
    poll(1);
    wb(1'b0, A_CT, 32'h0);
    check(32'(rd[6:5]), 32'h2);
    poll(2);
    r0 = rises;
    repeat (6 * BIT) @(posedge clk_i);
    check(rises - r0, 0);
    for (int i = 0; i < 2; i++) begin
      wb(1'b0, A_ST, 32'h0);
      check(32'(rd[2:1]), 32'h3);
      wb(1'b0, A_RX, 32'h0);
      check(32'(rd[7:0]), 32'h96);
    end
    wb(1'b1, A_CT, 32'h05);
    wb(1'b0, A_ST, 32'h0);
    check(32'(rd[2:1]), 32'h0);
    remote(9'h096);
    wb(1'b1, A_CT, 32'h45);
    r0 = rises;
    while (rises - r0 < 3) @(posedge clk_i);
    wb(1'b1, A_CT, 32'h05);
    repeat (4 * BIT) @(posedge clk_i);
    wb(1'b0, A_ST, 32'h0);
    check(32'(rd[1]), 32'h0);
    $display("t_cont done");
  endtask : t_cont
  // ==========================================================
  // Main sequence
  initial begin
    {rst_i, cyc_i, stb_i, we_i, restart, pin_q, pol_q, nine_q, dec_on} = 9'h100;
    {adr_i, sel_i, dat_i, word} = {8'h00, 4'h3, 32'h0, 9'h000};
    {n_mismatch, comparisons, cycles, rises, gap, idle_n} = '0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    dec_on = 1'b1;
    t_tx();
    t_pol();
    t_single();
    t_nine();
    t_cont();
    finish_test();
  end
endmodule : testbench
bind spat_top spat_chk u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_i, .ack_o,
  .transmit_clock_pin_o, .transmit_clock_pin_oe_o, .receive_data_pin_o, .receive_data_pin_oe_o, .tx_request_o);
